// ---- convolver_cfg.svh ----
// Constants of the 3x3 kernel convolver: register addresses, field positions,
// reset values and widths. Definitions only; included by the design package user.
`ifndef CONVOLVER_CFG_SVH
`define CONVOLVER_CFG_SVH

// ****************************************************************************
// Register addresses on the configuration port
// ****************************************************************************
`define ADR_ROW_LEN 3'h0
`define ADR_ALU_PROG 3'h1
`define ADR_LOAD_BANK0 3'h2
`define ADR_LOAD_BANK1 3'h3
`define ADR_INIT 3'h4
`define ADR_SEL_BANK0 3'h5
`define ADR_SEL_BANK1 3'h6
`define ADR_NOP 3'h7

// ****************************************************************************
// Initialization register fields
// ****************************************************************************
`define INIT_CASCADE_MODE 0
`define INIT_DELAY_LO 1
`define INIT_DELAY_HI 2
`define INIT_SIGNED_PIX 3
`define INIT_SIGNED_COEF 4
`define INIT_SHIFT_LO 7
`define INIT_SHIFT_HI 8

// ****************************************************************************
// Reset values and sizes
// ****************************************************************************
`define RST_ROW_LEN 10'h000
`define RST_ALU_PROG 10'h000
`define RST_INIT 10'h000
`define ROW_LEN_ZERO_MEANS 11'h400
`define LAST_COEF 4'h8

`endif

// ---- convolver_pkg.sv ----
// Types shared by the 3x3 kernel convolver.
// Assumes convolver_cfg.svh is compiled alongside.
package convolver_pkg;

   // ************************************************************************
   // Coefficient bank and pixel window: entry 0 is A, entry 8 is I
   // ************************************************************************
   typedef logic [8:0][7:0] kernel_t;

   typedef struct packed {
      logic [1:0] frame_sync;
      logic hold_q;
      logic [9:0] row_len;
      logic [9:0] alu_prog;
      logic [9:0] init;
      kernel_t bank0;
      kernel_t bank1;
      logic [3:0] idx0;
      logic [3:0] idx1;
      logic act_bank;
      logic [9:0] wptr;
      logic [11:0] fill;
      logic [2:0][7:0] delay;
      kernel_t win;
      logic [19:0] result;
      logic [9:0] rdata;
   } state_t;

endpackage

// ---- kernel_convolver.sv ----
// 3x3 image convolver with internal row buffers, FIR, external-buffer and
// cascade modes. Assumes one 125 MHz clock, pixels synchronous to it, and a
// frame-clear pin that may change at any time.
//
// Overview of operation
// - Mode comes from the initialization register and row length, writable any time.
// - Single chip: 3x3 convolution of 8-bit pixels, internal rows up to 1024.
// - Sum of nine products; A-C previous row, D-F current, G-I next.
// - Frame clear empties row buffers, window latches and result register.
// - Reset gives row length 1024, no delay, no ALU op, unsigned.
// - Processor may rewrite ALU, initialization and row length registers.
// - Reset zeroes both coefficient banks and selects bank zero.
// - Load the idle bank, then select it; output stream is not broken.
// - Row length 3 with cascade bit clear makes a nine-tap FIR.
// - FIR: A weights sample eight back, I the newest sample.
// - Cascade bit set: cascade bus feeds two kernel rows.
// - Input delay acts only on pixel input, the bottom row.
// - Address 101 selects bank zero, address 110 selects bank one.
// - Cascade bit clear: cascade value is added to the sum.
// - Hold sampled each edge freezes stream state, result and cascade outputs next cycle.
`timescale 1ns/100ps
`include "convolver_cfg.svh"

module kernel_convolver #(
   parameter int MAX_ROW = 1024
) (
   // Clock and reset
   input wire logic REF_CLK_I,
   input wire logic RST_B_I,
   // Stream control pins
   input wire logic FRAME_B_I,
   input wire logic HOLD_I,
   // Pixel and cascade data
   input wire logic [7:0] PIXEL_IN_BUS_I,
   input wire logic [15:0] CASCADE_IN_BUS_I,
   output logic [19:0] RESULT_OUT_BUS_O,
   output logic [7:0] CASCADE_OUT_O,
   // Configuration port
   input wire logic [2:0] ADDR_I,
   input wire logic [9:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [9:0] RDATA_O
);

   // *************************************************************************
   // State and row buffer storage
   // *************************************************************************
   convolver_pkg::state_t st;
   convolver_pkg::state_t next_st;
   logic [15:0] row_mem [MAX_ROW];
   logic [15:0] mem_word;
   logic [7:0] row1;
   logic [7:0] row2;
   logic [7:0] pix;
   logic [10:0] len;
   logic run;
   logic clear;

   assign clear = !st.frame_sync[1];
   assign run = !st.hold_q && !clear;
   assign mem_word = row_mem[st.wptr];
   assign len = (st.row_len == 10'h000) ? `ROW_LEN_ZERO_MEANS : {1'b0, st.row_len};
   // Rows read zero until the buffer has been filled since the last frame clear
   assign row1 = (st.fill >= {1'b0, len}) ? mem_word[7:0] : 8'h00;
   assign row2 = (st.fill >= {len, 1'b0}) ? mem_word[15:8] : 8'h00;

   // *************************************************************************
   // Programmable input delay on the pixel input only
   // *************************************************************************
   always_comb begin
      case (st.init[`INIT_DELAY_HI:`INIT_DELAY_LO])
         2'h0: pix = PIXEL_IN_BUS_I;
         2'h1: pix = st.delay[0];
         2'h2: pix = st.delay[1];
         default: pix = st.delay[2];
      endcase
   end

   // *************************************************************************
   // Next-state logic
   // *************************************************************************
   always_comb begin
      logic [15:0] cas_wide;
      logic signed [19:0] acc;
      logic signed [8:0] px9;
      logic signed [8:0] cf9;
      logic signed [17:0] prod;
      logic [7:0] top;
      logic [7:0] mid;
      convolver_pkg::kernel_t coef;
      cas_wide = 16'h0000;
      acc = 20'sh00000;
      px9 = 9'sh000;
      cf9 = 9'sh000;
      prod = 18'sh00000;
      top = 8'h00;
      mid = 8'h00;
      coef = st.act_bank ? st.bank1 : st.bank0;
      next_st = st;
      next_st.frame_sync = {st.frame_sync[0], FRAME_B_I};
      next_st.hold_q = HOLD_I;
      next_st.rdata = 10'h000;

      // Configuration writes are taken even while the stream is held
      if (WR_I) begin
         if (ADDR_I == `ADR_ROW_LEN) begin
            next_st.row_len = WDATA_I;
         end else if (ADDR_I == `ADR_ALU_PROG) begin
            next_st.alu_prog = WDATA_I;
         end else if (ADDR_I == `ADR_LOAD_BANK0) begin
            next_st.bank0[st.idx0] = WDATA_I[7:0];
            next_st.idx0 = (st.idx0 == `LAST_COEF) ? 4'h0 : st.idx0 + 4'h1;
         end else if (ADDR_I == `ADR_LOAD_BANK1) begin
            next_st.bank1[st.idx1] = WDATA_I[7:0];
            next_st.idx1 = (st.idx1 == `LAST_COEF) ? 4'h0 : st.idx1 + 4'h1;
         end else if (ADDR_I == `ADR_INIT) begin
            next_st.init = WDATA_I;
         end else if (ADDR_I == `ADR_SEL_BANK0) begin
            next_st.act_bank = 1'b0;
         end else if (ADDR_I == `ADR_SEL_BANK1) begin
            next_st.act_bank = 1'b1;
         end
      end

      // Read data stands in the cycle after the read strobe
      if (RD_I) begin
         if (ADDR_I == `ADR_ROW_LEN) begin
            next_st.rdata = st.row_len;
         end else if (ADDR_I == `ADR_ALU_PROG) begin
            next_st.rdata = st.alu_prog;
         end else if (ADDR_I == `ADR_LOAD_BANK0) begin
            next_st.rdata = {6'h00, st.idx0};
         end else if (ADDR_I == `ADR_LOAD_BANK1) begin
            next_st.rdata = {6'h00, st.idx1};
         end else if (ADDR_I == `ADR_INIT) begin
            next_st.rdata = st.init;
         end else if (ADDR_I == `ADR_SEL_BANK0 || ADDR_I == `ADR_SEL_BANK1) begin
            next_st.rdata = {9'h000, st.act_bank};
         end
      end

      // Sum of nine products on the current window
      for (int k = 0; k < 9; k++) begin
         px9 = {st.init[`INIT_SIGNED_PIX] & st.win[k][7], st.win[k]};
         cf9 = {st.init[`INIT_SIGNED_COEF] & coef[k][7], coef[k]};
         prod = px9 * cf9;
         acc = acc + 20'(prod);
      end
      if (!st.init[`INIT_CASCADE_MODE]) begin
         case (st.init[`INIT_SHIFT_HI:`INIT_SHIFT_LO])
            2'h0: cas_wide = CASCADE_IN_BUS_I;
            default: cas_wide = CASCADE_IN_BUS_I;
         endcase
         case (st.init[`INIT_SHIFT_HI:`INIT_SHIFT_LO])
            2'h0: acc = acc + 20'({4'h0, cas_wide});
            2'h1: acc = acc + 20'({2'h0, cas_wide, 2'h0});
            2'h2: acc = acc + 20'({cas_wide, 4'h0});
            default: acc = acc + {cas_wide[11:0], 8'h00};
         endcase
      end

      // Rows above the pixel input: internal buffers or the cascade bus
      if (st.init[`INIT_CASCADE_MODE]) begin
         top = CASCADE_IN_BUS_I[15:8];
         mid = CASCADE_IN_BUS_I[7:0];
      end else begin
         top = row2;
         mid = row1;
      end

      // Stream advances one pixel per cycle unless held or in frame clear
      if (run) begin
         next_st.delay = {st.delay[1:0], PIXEL_IN_BUS_I};
         // Columns shift left: entry 3r+2 is newest, 3r is oldest (n-2)
         next_st.win[0] = st.win[1];
         next_st.win[1] = st.win[2];
         next_st.win[2] = top;
         next_st.win[3] = st.win[4];
         next_st.win[4] = st.win[5];
         next_st.win[5] = mid;
         next_st.win[6] = st.win[7];
         next_st.win[7] = st.win[8];
         next_st.win[8] = pix;
         next_st.wptr = (11'(st.wptr) == len - 11'h001) ? 10'h000 : st.wptr + 10'h001;
         if (st.fill < {len, 1'b0}) begin
            next_st.fill = st.fill + 12'h001;
         end
         next_st.result = acc;
      end

      if (clear) begin
         next_st.delay = '0;
         next_st.win = '0;
         next_st.wptr = 10'h000;
         next_st.fill = 12'h000;
         next_st.result = 20'h00000;
      end
   end

   // *************************************************************************
   // State register
   // *************************************************************************
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_B_I) begin
         st <= '0;
         st.row_len <= `RST_ROW_LEN;
         st.alu_prog <= `RST_ALU_PROG;
         st.init <= `RST_INIT;
         st.bank0 <= '0;
         st.bank1 <= '0;
         st.act_bank <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // *************************************************************************
   // Row buffer: low byte is the first row, high byte the second
   // *************************************************************************
   always_ff @(posedge REF_CLK_I) begin
      if (RST_B_I && run) begin
         row_mem[st.wptr] <= {mem_word[7:0], pix};
      end
   end

   // *************************************************************************
   // Outputs
   // *************************************************************************
   assign RESULT_OUT_BUS_O = st.result;
   assign CASCADE_OUT_O = row2;
   assign RDATA_O = st.rdata;

endmodule

// ---- conv_asserts.sv ----
// Port checker of the 3x3 convolver: register port and stream control.
// Bound into kernel_convolver; sees only its ports.
`timescale 1ns/100ps
module conv_asserts #(
   parameter int MAX_ROW = 1024
) (
   // Clock and reset
   input wire logic REF_CLK_I,
   input wire logic RST_B_I,
   // Stream
   input wire logic FRAME_B_I,
   input wire logic HOLD_I,
   input wire logic [7:0] PIXEL_IN_BUS_I,
   input wire logic [15:0] CASCADE_IN_BUS_I,
   input wire logic [19:0] RESULT_OUT_BUS_O,
   input wire logic [7:0] CASCADE_OUT_O,
   // Register port
   input wire logic [2:0] ADDR_I,
   input wire logic [9:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   input wire logic [9:0] RDATA_O
);
   // ************************************************************
   // Properties
   // ************************************************************
   default clocking dc @(posedge REF_CLK_I);
   endclocking
   default disable iff (!RST_B_I);

   AST_RST_RES: assert property ($rose(RST_B_I) |-> RESULT_OUT_BUS_O == 20'h00000)
      else $error("Result not clear after reset");
   AST_RD_IDLE: assert property (!$past(RD_I) |-> RDATA_O == 10'h000)
      else $error("Read data outside its slot");
   AST_RD_NOP: assert property (RD_I && ADDR_I == 3'h7 |=> RDATA_O == 10'h000)
      else $error("No-operation address read nonzero");
   AST_RD_BACK:
   assert property (WR_I && ADDR_I inside {3'h0, 3'h1, 3'h4} ##1
      RD_I && ADDR_I == $past(ADDR_I) |=> RDATA_O == $past(WDATA_I, 2))
      else $error("Register read back differs");
   AST_SEL_BANK:
   assert property (WR_I && ADDR_I inside {3'h5, 3'h6} ##1 RD_I && ADDR_I inside {3'h5, 3'h6}
      |=> RDATA_O[0] == ($past(ADDR_I, 2) == 3'h6)) else $error("Active bank wrong");
   AST_HOLD_FREEZE:
   assert property (HOLD_I && FRAME_B_I && $past(FRAME_B_I) |-> ##2
      $stable(RESULT_OUT_BUS_O) && $stable(CASCADE_OUT_O)) else $error("Hold did not freeze");
   AST_FRAME_RES: assert property ((!FRAME_B_I && !HOLD_I) [*4] |-> RESULT_OUT_BUS_O == 0)
      else $error("Frame clear left result");
   AST_FRAME_CASO: assert property ((!FRAME_B_I && !HOLD_I) [*4] |-> CASCADE_OUT_O == 0)
      else $error("Frame clear left row buffer");
   COV_HOLD: cover property (HOLD_I ##1 !HOLD_I);
   COV_SEL: cover property (WR_I && ADDR_I == 3'h6);
   COV_FRAME: cover property (!FRAME_B_I [*4]);
endmodule

bind kernel_convolver conv_asserts #(.MAX_ROW(MAX_ROW)) i_chk (.REF_CLK_I, .RST_B_I,
   .FRAME_B_I, .HOLD_I, .PIXEL_IN_BUS_I, .CASCADE_IN_BUS_I, .RESULT_OUT_BUS_O,
   .CASCADE_OUT_O, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O);

// ---- pix_src.sv ----
// Pixel source: one new raster-order pixel after every rising clock edge.
// Assumes the convolver clock; values come from a fixed seed.
`timescale 1ns/100ps
module pix_src #(
   parameter logic [31:0] SEED = 32'h8f52dd3b
) (
   // Clock
   input wire logic clk_i,
   // Pixel out
   output logic [7:0] pix_o
);
   integer seed = SEED;
   initial pix_o = 8'h00;
   always @(posedge clk_i) pix_o <= 8'($random(seed));
endmodule

// ---- tb_top.sv ----
// Self-checking bench of the 3x3 convolver run as a nine-tap line filter and with the cascade bus feeding two rows.
// Assumes convolver_cfg.svh, convolver_pkg.sv and the checker are compiled first.
`timescale 1ns/100ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin errors++; \
   $display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb_top;
   logic clk = 1'b0, rst_b = 1'b0, frame_b = 1'b1, hold = 1'b0, wr = 1'b0, rd = 1'b0;
   logic run = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [9:0] wdata = 10'h000, rdata;
   logic [15:0] casc = 16'h0000;
   logic [7:0] pix, caso;
   logic [19:0] result;
   integer seed = 32'h8f52dd3b;
   int errors = 0, samples_checked = 0, cq = 0, s;
   int hist[$];
   int chist[$];
   int px, ext = 0, sh = 0, dly = 0;
   int mode_init[4] = '{'h001, 'h004, 'h080, 'h180};
   int mode_sh[4] = '{0, 0, 2, 8};
   int mode_dly[4] = '{0, 2, 0, 0};
   int cf[9] = '{default: 0};
   int nb[9];
   int rst_adr[6] = '{0, 1, 4, 5, 2, 3};

   kernel_convolver #(.MAX_ROW(1024)) i_dut (.REF_CLK_I(clk), .RST_B_I(rst_b),
      .FRAME_B_I(frame_b), .HOLD_I(hold), .PIXEL_IN_BUS_I(pix), .CASCADE_IN_BUS_I(casc),
      .RESULT_OUT_BUS_O(result), .CASCADE_OUT_O(caso), .ADDR_I(addr), .WDATA_I(wdata),
      .WR_I(wr), .RD_I(rd), .RDATA_O(rdata));
   pix_src i_src (.clk_i(clk), .pix_o(pix));

   initial forever #4 clk = ~clk;
   // Random bytes stand in for the two external row buffer outputs
   always @(posedge clk) casc <= 16'($random(seed));

   // ************************************************************
   // Reference model: nine latest pixels plus the cascade value, or six cascade bytes and three pixels in cascade mode
   // ************************************************************
   always @(posedge clk) begin
      if (!run) begin
         hist.delete();
         chist.delete();
      end else begin
         if (hist.size() >= 16) begin
            s = ext ? 0 : (cq << sh);
            for (int i = 0; i < 9; i++) begin
               if (ext == 0) px = hist[hist.size() - 10 - dly + i];
               else if (i < 6) px = (chist[chist.size() - 4 + i % 3] >> (8 - 8 * (i / 3))) & 255;
               else px = hist[hist.size() - 10 + i];
               s += cf[i] * px;
            end
            `CHK("result", 20'(s), result)
         end
         hist.push_back(pix);
         chist.push_back(casc);
      end
      cq = casc;
   end

   task automatic wr_reg(input logic [2:0] a, input logic [9:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [2:0] a, input logic [9:0] e);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      `CHK("rdata", e, rdata)
   endtask
   task automatic load_bank(input logic [2:0] a, input logic [8:0] m);
      for (int i = 0; i < 9; i++) begin
         nb[i] = m[i] ? ($random(seed) & 255) : 0;
         wr_reg(a, 10'(nb[i]));
      end
   endtask
   task automatic frame_clear;
      @(posedge clk);
      frame_b <= 1'b0;
      repeat (6) @(posedge clk);
      frame_b <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
   task automatic give_verdict;
      $display("Checks %0d, errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge clk);
      errors++;
      give_verdict();
   end

   initial begin
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      foreach (rst_adr[i]) rd_reg(3'(rst_adr[i]), 10'h000);
      wr_reg(3'h1, 10'h2a5);
      rd_reg(3'h1, 10'h2a5);
      wr_reg(3'h0, 10'h003);
      rd_reg(3'h0, 10'h003);
      rd_reg(3'h7, 10'h000);
      frame_clear();
      run <= 1'b1;
      repeat (30) @(posedge clk);
      run <= 1'b0;
      load_bank(3'h2, 9'h1c7);
      rd_reg(3'h2, 10'h000);
      wr_reg(3'h5, 10'h000);
      rd_reg(3'h5, 10'h000);
      cf = nb;
      run <= 1'b1;
      repeat (30) @(posedge clk);
      load_bank(3'h3, 9'h1ff);
      run <= 1'b0;
      wr_reg(3'h6, 10'h000);
      rd_reg(3'h6, 10'h001);
      cf = nb;
      run <= 1'b1;
      repeat (30) @(posedge clk);
      run <= 1'b0;
      hold <= 1'b1;
      repeat (3) @(posedge clk);
      hold <= 1'b0;
      repeat (2) @(posedge clk);
      run <= 1'b1;
      repeat (30) @(posedge clk);
      run <= 1'b0;
      foreach (mode_init[i]) begin
         wr_reg(3'h4, 10'(mode_init[i]));
         ext = (i == 0);
         dly = mode_dly[i];
         sh = mode_sh[i];
         run <= 1'b1;
         repeat (30) @(posedge clk);
         run <= 1'b0;
      end
      frame_clear();
      give_verdict();
   end
endmodule
